// ### core/osc_pkg.sv
// Purpose: shared constants and types for the output clock sync block
// Assumes: one sample clock domain, APB register access with 32-bit data
// Notes: every offset, field position and cycle count lives here, and the control reset value
package osc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    // control field positions
    localparam int CTRL_EXT_BIT = 0;      // extended_register_control
    localparam int CTRL_RSTEN_BIT = 1;    // out clock reset mechanism enable
    localparam int CTRL_ALIGN_BIT = 2;    // master_slave_alignment enable
    localparam int CTRL_MASTER_BIT = 3;   // this device is the master
    localparam int CTRL_SPLIT_BIT = 4;    // one-to-two output split mode
    localparam int CTRL_DDR_PHASE_SELECT_BIT = 5;    // ddr_phase_select
    localparam int CTRL_ADJ_LSB = 8;      // aperture delay adjust, 3 bits
    localparam int CTRL_ADJ_W = 3;
    localparam int CTRL_W = 11;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
    // status field positions
    localparam int STAT_PHASE_LSB = 0;    // current divider phase, 2 bits
    localparam int STAT_HOLD_BIT = 2;     // output clock held by reset
    localparam int STAT_COUNT_BIT = 3;    // counting toward the sync edge
    localparam int STAT_ARMED_BIT = 4;    // a first reset pulse has been seen
    localparam int STAT_LOCK_BIT = 5;     // last reference edge matched phase
    // timing counts in sample clock cycles
    localparam logic [2:0] SYNC_DLY_90 = 3'h4;
    localparam logic [2:0] SYNC_DLY_0 = 3'h5;
    localparam int FIXED_LAT_CYC = 2;
    localparam int OUT_DELAY_CYC = 4;
    localparam int DLY_DEPTH = 8;
    localparam int TAP_W = 3;
    localparam logic [TAP_W-1:0] TAP_NOMINAL = 3'h6;
    // phase the slave loads on a reference edge: sync and edge stages eat 3 cycles
    localparam logic [1:0] ALIGN_PHASE = 2'h3;
    localparam logic [1:0] SYNC_PHASE = 2'h0;
    // sequencer states, one-hot
    typedef enum logic [2:0] {
        OSC_RUN = 3'b001,
        OSC_HOLD = 3'b010,
        OSC_COUNT = 3'b100
    } osc_state_t;
endpackage

// ### core/osc_dly_if.sv
// Purpose: carries the raw clock bit and tap choice to the delay line
// Assumes: both ends run on the sample clock
// Notes: no clocking block; plain signals only
`timescale 1ns/1ps
interface osc_dly_if;
    logic d;
    logic [osc_pkg::TAP_W-1:0] tap;
    logic q;
    modport src (output d, output tap, input q);
    modport dly (input d, input tap, output q);
endinterface

// ### core/osc_delay_line.sv
// Purpose: tapped delay line that places the output data clock in time
// Assumes: tap changes are rare; a change may glitch the output once
// Notes: output comes from a flip-flop after the tap mux
`timescale 1ns/1ps
module osc_delay_line #(
    parameter int DEPTH = osc_pkg::DLY_DEPTH
) (
    input wire logic i_mclk,   // sample clock
    input wire logic i_rst_b,  // sync reset, active low
    osc_dly_if.dly port        // clock bit in, tap, delayed bit out
);
    logic [DEPTH-1:0] line_reg;
    logic [DEPTH-1:0] line_next;
    logic q_reg;
    logic q_next;

    // shift in the raw bit and pick the requested tap
    always_comb begin
        line_next = {line_reg[DEPTH-2:0], port.d};
        q_next = line_reg[port.tap];
    end

    // registers only
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            line_reg <= '0;
            q_reg <= 1'b0;
        end else begin
            line_reg <= line_next;
            q_reg <= q_next;
        end
    end

    assign port.q = q_reg;
endmodule

// ### core/osc_top.sv
// Purpose: output data clock phase sync (master/slave alignment and pulse reset)
// Assumes: i_mclk stands in for the sample clock; pins are asynchronous to it
// Notes: control and status are reached over APB at two word offsets
// Notes: the pulse reset and the alignment share one divider
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module osc_top (
    input wire logic i_mclk,                 // sample clock, 200 MHz
    input wire logic i_rst_b,                // sync reset, active low
    input wire logic i_psel,                 // apb select
    input wire logic i_penable,              // apb enable
    input wire logic i_pwrite,               // apb direction, high is write
    input wire logic [7:0] i_paddr,          // apb byte address
    input wire logic [31:0] i_pwdata,        // apb write data
    output logic [31:0] o_prdata,            // apb read data
    output logic o_pready,                   // apb ready
    output logic o_pslverr,                  // apb error, unmapped address
    input wire logic i_out_clock_reset_in,   // async output clock reset pin
    input wire logic i_sync_reference_in,    // reference clock from the master
    output logic o_first_channel_out_clock,  // first channel output data clock
    output logic o_second_channel_out_clock, // second channel output data clock
    output logic o_sync_reference_out_a,     // reference to downstream slave a
    output logic o_sync_reference_out_b,     // reference to downstream slave b
    output logic o_second_bus_oe             // secondary split bus drive enable
);
    // decode of the address, used by the error path only; reads compare offsets directly
    // anything outside the two words answers with an error and changes nothing
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == osc_pkg::OFS_CTRL) || (a == osc_pkg::OFS_STATUS);
    endfunction

    // carrier to the delay line; the top itself keeps plain ports
    osc_dly_if dly_if ();

    // apb and control state
    logic [osc_pkg::CTRL_W-1:0] ctrl_reg;
    logic [osc_pkg::CTRL_W-1:0] ctrl_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    // synchronisers
    logic rst_s1_reg;
    logic rst_s2_reg;
    logic rst_s3_reg;
    logic ref_s1_reg;
    logic ref_s2_reg;
    logic ref_s3_reg;
    // clock generation state
    // phase is the quarter-rate divider shared by both channels
    // armed remembers that a first pulse has passed since reset
    osc_pkg::osc_state_t state_reg;
    osc_pkg::osc_state_t state_next;
    logic [1:0] phase_reg;
    logic [1:0] phase_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic armed_reg;
    logic armed_next;
    logic lock_reg;
    logic lock_next;
    logic ref_out_reg;
    logic ref_out_next;
    logic oe_reg;
    logic oe_next;
    logic raw_clk;

    // control field views
    // the views keep every bit position in the package alone
    logic ext_en;
    logic rst_en;
    logic align_en;
    logic is_master;
    logic split;
    logic ddr_phase_select;
    logic [osc_pkg::CTRL_ADJ_W-1:0] adj;
    logic setup;
    logic rst_edge_rise;
    logic rst_edge_fall;
    logic ref_rise;

    assign ext_en = ctrl_reg[osc_pkg::CTRL_EXT_BIT];
    assign rst_en = ext_en && ctrl_reg[osc_pkg::CTRL_RSTEN_BIT];
    assign align_en = ctrl_reg[osc_pkg::CTRL_ALIGN_BIT];
    assign is_master = ctrl_reg[osc_pkg::CTRL_MASTER_BIT];
    assign split = ctrl_reg[osc_pkg::CTRL_SPLIT_BIT];
    assign ddr_phase_select = ctrl_reg[osc_pkg::CTRL_DDR_PHASE_SELECT_BIT];
    assign adj = ctrl_reg[osc_pkg::CTRL_ADJ_LSB +: osc_pkg::CTRL_ADJ_W];
    assign setup = i_psel && !i_penable;

    // apb slave: answer is prepared in setup so the access phase needs no wait
    always_comb begin
        ctrl_next = ctrl_reg;
        prdata_next = prdata_reg;
        pready_next = setup;
        pslverr_next = setup && !addr_mapped(i_paddr);
        // read data is built from the state seen at the setup edge
        if (setup && !i_pwrite) begin
            prdata_next = 32'h00000000;
            if (i_paddr == osc_pkg::OFS_CTRL) begin
                prdata_next[osc_pkg::CTRL_W-1:0] = ctrl_reg;
            end else if (i_paddr == osc_pkg::OFS_STATUS) begin
                prdata_next[osc_pkg::STAT_PHASE_LSB +: 2] = phase_reg;
                prdata_next[osc_pkg::STAT_HOLD_BIT] = (state_reg == osc_pkg::OSC_HOLD);
                prdata_next[osc_pkg::STAT_COUNT_BIT] = (state_reg == osc_pkg::OSC_COUNT);
                prdata_next[osc_pkg::STAT_ARMED_BIT] = armed_reg;
                prdata_next[osc_pkg::STAT_LOCK_BIT] = lock_reg;
            end
        end
        // write lands in the access cycle, the edge where ready is seen high
        // status writes fall through and are ignored
        if (i_psel && i_penable && i_pwrite && pready_reg && (i_paddr == osc_pkg::OFS_CTRL)) begin
            ctrl_next = i_pwdata[osc_pkg::CTRL_W-1:0];
        end
    end

    // registers only; ready is a one-cycle pulse, so setups may follow back to back
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            ctrl_reg <= osc_pkg::CTRL_RESET;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // pin synchronisers; stage three exists only so edges never read stage one
    // both pins are asynchronous to the sample clock, so two flops come first
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
            rst_s3_reg <= 1'b0;
            ref_s1_reg <= 1'b0;
            ref_s2_reg <= 1'b0;
            ref_s3_reg <= 1'b0;
        end else begin
            rst_s1_reg <= i_out_clock_reset_in;
            rst_s2_reg <= rst_s1_reg;
            rst_s3_reg <= rst_s2_reg;
            ref_s1_reg <= i_sync_reference_in;
            ref_s2_reg <= ref_s1_reg;
            ref_s3_reg <= ref_s2_reg;
        end
    end

    // edges compare stages two and three; a pin pulse shorter than one
    // sample period may be missed entirely
    assign rst_edge_rise = rst_s2_reg && !rst_s3_reg;
    assign rst_edge_fall = !rst_s2_reg && rst_s3_reg;
    assign ref_rise = ref_s2_reg && !ref_s3_reg;

    // divider, alignment and pulse-reset sequencer
    // the divider always advances; alignment and the sync edge only reload it,
    // which keeps the duty steady instead of stalling the output clock
    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg + 2'h1;
        cnt_next = cnt_reg;
        armed_next = armed_reg;
        lock_next = lock_reg;
        // slave realigns on every reference edge except one landing with an armed sync reload, which wins; no special pulse needed
        if (align_en && !is_master && ref_rise) begin
            phase_next = osc_pkg::ALIGN_PHASE;
            // lock only reports; it never gates the realignment
            lock_next = (phase_reg + 2'h1 == osc_pkg::ALIGN_PHASE);
        end
        case (state_reg)
            osc_pkg::OSC_RUN: begin
                // the pin is sampled, so assertion at any time is safe
                if (rst_en && rst_edge_rise) begin
                    state_next = osc_pkg::OSC_HOLD;
                end
            end
            osc_pkg::OSC_HOLD: begin
                // dropping the enable abandons the pulse and lets the clock run on
                if (!rst_en) begin
                    state_next = osc_pkg::OSC_RUN;
                end else if (rst_edge_fall) begin
                    // this cycle is the first edge past release; count from here
                    state_next = osc_pkg::OSC_COUNT;
                    // the reload lands that many edges after this one
                    cnt_next = ddr_phase_select ? osc_pkg::SYNC_DLY_90 : osc_pkg::SYNC_DLY_0;
                end
            end
            osc_pkg::OSC_COUNT: begin
                if (cnt_reg == 3'h1) begin
                    state_next = osc_pkg::OSC_RUN;
                    armed_next = 1'b1;
                    // first pulse after power-on only arms; phase is left as found
                    if (armed_reg) begin
                        phase_next = osc_pkg::SYNC_PHASE;
                    end
                end else begin
                    cnt_next = cnt_reg - 3'h1;
                end
            end
            default: begin
                // an illegal code falls back to free running
                state_next = osc_pkg::OSC_RUN;
            end
        endcase
    end

    // registers only
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            state_reg <= osc_pkg::OSC_RUN;
            phase_reg <= 2'h0;
            cnt_reg <= 3'h0;
            armed_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
            armed_reg <= armed_next;
            lock_reg <= lock_next;
        end
    end

    // raw clock bit: quarter rate in split mode, held high while reset holds it
    // non-split runs at half rate, one data word per output clock edge
    always_comb begin
        if (split) begin
            raw_clk = (phase_reg[1] == 1'b0);
            if (state_reg != osc_pkg::OSC_RUN) begin
                raw_clk = 1'b1;
            end
        end else begin
            raw_clk = phase_reg[0];
        end
    end

    // reference out rises as the phase wraps to zero; slaves forward their own
    always_comb begin
        ref_out_next = (phase_next[1] == 1'b0);
        oe_next = split;
    end

    // registered so downstream slaves see clean edges
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            ref_out_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            ref_out_reg <= ref_out_next;
            oe_reg <= oe_next;
        end
    end

    // tap = latency + output delay - adjust; large adjust clamps to tap zero
    // a tap change may glitch the output once, so adjust while idle
    assign dly_if.d = raw_clk;
    assign dly_if.tap = (adj > osc_pkg::TAP_NOMINAL) ? '0 : osc_pkg::TAP_NOMINAL - adj;

    // the line sits in its own module so its depth can change alone
    osc_delay_line #(
        .DEPTH(osc_pkg::DLY_DEPTH)
    ) u_delay (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .port(dly_if.dly)
    );

    // one flop feeds both channels, so they cannot drift apart
    assign o_first_channel_out_clock = dly_if.q;
    assign o_second_channel_out_clock = dly_if.q;
    assign o_sync_reference_out_a = ref_out_reg;
    assign o_sync_reference_out_b = ref_out_reg;
    assign o_second_bus_oe = oe_reg;
    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    // synchronous sampling removes the narrow pulse at assertion; a hold may still
    // cut a phase short, which capture logic must tolerate; since every stage is
    // registered, any shortened phase still lasts at least one sample period
endmodule

// ### test/osc_peer_model.sv
// Purpose: master converter seen from a slave, sending its reference clock
// Assumes: zero wire delay between master and slave
// Notes: slip holds the divider one cycle to model an upset on the master side
`timescale 1ns/1ps
module osc_peer_model (
    input wire logic i_mclk,  // sample clock
    input wire logic i_rst_b, // sync reset, active low
    input wire logic i_slip,  // hold the phase one cycle
    output logic o_ref        // reference, high on phases 0 and 1
);
    logic [1:0] ph_reg, ph_next;
    // quarter rate divider of the master
    always_comb begin
        ph_next = i_slip ? ph_reg : ph_reg + 2'h1;
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            ph_reg <= 2'h0;
        end else begin
            ph_reg <= ph_next;
        end
    end
    assign o_ref = !ph_reg[1];
endmodule

// ### test/osc_top_monitor.sv
// Purpose: port checks for the output clock sync block
// Assumes: control is tracked from APB writes seen at the access edge
// Notes: pin checks wait 12 cycles so old delay line contents are flushed
`timescale 1ns/1ps
module osc_chk (
    input wire logic i_mclk,                     // sample clock
    input wire logic i_rst_b,                    // sync reset
    input wire logic i_psel,                     // apb select
    input wire logic i_penable,                  // apb enable
    input wire logic i_pwrite,                   // apb direction
    input wire logic [7:0] i_paddr,              // apb address
    input wire logic [31:0] i_pwdata,            // apb write data
    input wire logic [31:0] o_prdata,            // apb read data
    input wire logic o_pready,                   // apb ready
    input wire logic o_pslverr,                  // apb error
    input wire logic i_out_clock_reset_in,       // reset pin
    input wire logic i_sync_reference_in,        // reference in
    input wire logic o_first_channel_out_clock,  // clock a
    input wire logic o_second_channel_out_clock, // clock b
    input wire logic o_sync_reference_out_a,     // ref out a
    input wire logic o_sync_reference_out_b,     // ref out b
    input wire logic o_second_bus_oe             // split bus enable
);
    logic [10:0] ctl_reg, ctl_next;
    logic [4:0] hi_reg, hi_next;
    logic long_hi;
    // shadow control; count pin-high cycles, saturating
    always_comb begin
        ctl_next = ctl_reg;
        hi_next = 5'h00;
        if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 8'h00) begin
            ctl_next = i_pwdata[10:0];
        end
        if (i_out_clock_reset_in) begin
            hi_next = (hi_reg == 5'h1F) ? hi_reg : hi_reg + 5'h01;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            ctl_reg <= 11'h000;
            hi_reg <= 5'h00;
        end else begin
            ctl_reg <= ctl_next;
            hi_reg <= hi_next;
        end
    end
    assign long_hi = hi_reg >= 5'h0C;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    property p_rdy; i_psel && !i_penable |=> o_pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_lone; o_pready |-> $past(i_psel && !i_penable); endproperty
    a_lone: assert property (p_lone) else $error("ready without setup");
    property p_err; o_pslverr |-> o_pready && i_paddr != 8'h00 && i_paddr != 8'h04; endproperty
    a_err: assert property (p_err) else $error("error on mapped address");
    property p_pair; o_first_channel_out_clock == o_second_channel_out_clock; endproperty
    a_pair: assert property (p_pair) else $error("channel clocks differ");
    property p_refs; o_sync_reference_out_a == o_sync_reference_out_b; endproperty
    a_refs: assert property (p_refs) else $error("reference outputs differ");
    property p_oe; $changed(o_second_bus_oe) |-> $past(o_pready && i_pwrite) || $past(o_pready && i_pwrite, 2);
    endproperty
    a_oe: assert property (p_oe) else $error("bus enable moved without write");
    property p_hold; long_hi && ctl_reg[0] && ctl_reg[1] && ctl_reg[4] |-> o_first_channel_out_clock; endproperty
    a_hold: assert property (p_hold) else $error("split clock not held high");
    property p_tog; long_hi && !ctl_reg[4] |-> o_first_channel_out_clock != $past(o_first_channel_out_clock);
    endproperty
    a_tog: assert property (p_tog) else $error("non-split clock stopped");
    property p_off; long_hi && !ctl_reg[0] && ctl_reg[4] |-> ##[1:4] !o_first_channel_out_clock; endproperty
    a_off: assert property (p_off) else $error("pulse reset acted without ext");
    c_err: cover property (o_pslverr);
    c_hold: cover property (long_hi && ctl_reg[4] && ctl_reg[0]);
    c_ddr0: cover property ($fell(i_out_clock_reset_in) && !ctl_reg[5] && ctl_reg[0]);
    c_off: cover property (long_hi && !ctl_reg[0] && ctl_reg[4]);
endmodule
bind osc_top osc_chk u_chk (.i_mclk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_out_clock_reset_in, .i_sync_reference_in, .o_first_channel_out_clock,
    .o_second_channel_out_clock, .o_sync_reference_out_a, .o_sync_reference_out_b, .o_second_bus_oe);

// ### test/test_output_clock_sync.sv
// Purpose: self-checking bench for the output clock sync block
// Assumes: pin and reference driven on the sample clock, so sync latency is fixed
// Notes: pulse timing is judged by the lag from release to the first fall
`timescale 1ns/1ps
module test_output_clock_sync;
    logic i_mclk, i_rst_b, i_psel, i_penable, i_pwrite, i_out_clock_reset_in, slip;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, r;
    logic o_pready, o_pslverr, i_sync_reference_in, o_first_channel_out_clock;
    logic o_second_channel_out_clock, o_sync_reference_out_a, o_sync_reference_out_b, o_second_bus_oe;
    logic [32:0] q[$];
    logic [32:0] exp_w;
    logic [31:0] seed = 32'h0000000C;
    logic [7:0] la, lb, lc;
    int failures = 0;
    int total_checks = 0;
    osc_top u_dut (.i_mclk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .i_out_clock_reset_in, .i_sync_reference_in, .o_first_channel_out_clock,
        .o_second_channel_out_clock, .o_sync_reference_out_a, .o_sync_reference_out_b, .o_second_bus_oe);
    osc_peer_model u_peer (.i_mclk, .i_rst_b, .i_slip(slip), .o_ref(i_sync_reference_in));
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic lost();
        failures++;
        tally_and_finish();
    endtask
    task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // one transfer; the expected {error, read data} is noted for the watcher
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        @(posedge i_mclk);
        q.push_back(e);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            lost();
        end
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    // watcher: each completed transfer takes the oldest note
    always @(posedge i_mclk) begin
        if (o_pready === 1'b1) begin
            exp_w = (q.size() > 0) ? q.pop_front() : 33'h1FFFFFFFF;
            chk_bus({o_pslverr, i_pwrite ? 32'h0 : o_prdata}, exp_w);
        end
    end
    // hold the pin 17 cycles, check the clock meanwhile, then time the first fall
    task automatic pulse(input logic hold, output logic [7:0] lag);
        logic s0, prev, done;
        i_out_clock_reset_in <= 1'b1;
        repeat (16) @(posedge i_mclk);
        s0 = o_first_channel_out_clock;
        @(posedge i_mclk);
        if (hold) begin
            chk_val({7'h0, s0 & o_first_channel_out_clock}, 8'h01);
        end else begin
            chk_val({7'h0, s0 ^ o_first_channel_out_clock}, 8'h01);
        end
        i_out_clock_reset_in <= 1'b0;
        lag = 8'h00;
        prev = 1'b1;
        done = 1'b0;
        while (!done) begin
            @(posedge i_mclk);
            lag = lag + 8'h01;
            done = prev && !o_first_channel_out_clock;
            prev = o_first_channel_out_clock;
            if (lag == 8'h40) begin
                lost();
            end
        end
        repeat (8) @(posedge i_mclk);
    endtask
    // slave reference output must track the master's
    task automatic follow();
        repeat (8) begin
            @(posedge i_mclk);
            chk_val({7'h0, o_sync_reference_out_a}, {7'h0, i_sync_reference_in});
        end
    endtask
    initial begin
        {i_rst_b, i_psel, i_penable, i_pwrite, i_out_clock_reset_in, slip} = 6'h00;
        i_paddr = 8'h00;
        i_pwdata = 32'h0;
        repeat (8) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        apb(1'b0, 8'h00, 32'h0, 33'h0);
        apb(1'b0, 8'h08, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 8'h0C, xs(), {1'b1, 32'h0});
        repeat (4) begin
            r = xs();
            apb(1'b1, 8'h00, r, 33'h0);
            apb(1'b0, 8'h00, 32'h0, {1'b0, 21'h0, r[10:0]});
            chk_val({7'h0, o_second_bus_oe}, {7'h0, r[4]});
        end
        // same phase select for the first three pulses, as all masters must carry
        apb(1'b1, 8'h00, 32'h00000033, 33'h0);
        pulse(1'b1, la);
        pulse(1'b1, la);
        // lag: two sync flops and detect, two high phases, line entry, output flop, bench read
        chk_val(la, 8'h08 + {5'h00, osc_pkg::SYNC_DLY_90} + {5'h00, osc_pkg::TAP_NOMINAL});
        pulse(1'b1, lb);
        chk_val(lb, la);
        apb(1'b1, 8'h00, 32'h00000013, 33'h0);
        pulse(1'b1, lb);
        chk_val(lb, la + {5'h00, osc_pkg::SYNC_DLY_0} - {5'h00, osc_pkg::SYNC_DLY_90});
        apb(1'b1, 8'h00, 32'h00000213, 33'h0);
        pulse(1'b1, lc);
        chk_val(lc, lb - 8'h02);
        apb(1'b1, 8'h00, 32'h00000003, 33'h0);
        pulse(1'b0, lc);
        // pulse enable without extended control: the split clock must keep running
        apb(1'b1, 8'h00, 32'h00000012, 33'h0);
        i_out_clock_reset_in <= 1'b1;
        repeat (16) @(posedge i_mclk);
        i_out_clock_reset_in <= 1'b0;
        apb(1'b1, 8'h00, 32'h00000014, 33'h0);
        repeat (12) @(posedge i_mclk);
        follow();
        slip <= 1'b1;
        @(posedge i_mclk);
        slip <= 1'b0;
        repeat (12) @(posedge i_mclk);
        follow();
        tally_and_finish();
    end
endmodule
